//--- hdl/smd_pkg.sv
// Package: constants, register map and types of the stepper PWM driver
package smd_pkg;

  // Register addresses
  localparam logic [15:0] SMD_MODE_ADDR = 16'hf9c0;
  localparam logic [15:0] SMD_DCS_ADDR = 16'hf9d0;
  localparam logic [15:0] SMD_SIN_ADDR [4] =
    '{16'hf9c2, 16'hf9c4, 16'hf9c6, 16'hf9c8};
  localparam logic [15:0] SMD_COS_ADDR [4] =
    '{16'hf9c3, 16'hf9c5, 16'hf9c7, 16'hf9c9};
  localparam logic [15:0] SMD_CTL_ADDR [4] =
    '{16'hf9ca, 16'hf9cc, 16'hf9ce, 16'hf9f8};

  // Counter mode control fields
  localparam int SMD_M_EN = 7;
  localparam int SMD_M_FULL = 5;
  localparam int SMD_M_RUN = 4;
  localparam int SMD_M_SRC = 3;
  localparam logic [7:0] SMD_MODE_WMASK = 8'hbf;

  // Channel control fields
  localparam int SMD_C_AOUT = 7;
  localparam int SMD_C_WIN = 6;
  localparam int SMD_C_ZPD = 5;
  localparam int SMD_C_TEN = 4;
  localparam int SMD_C_ADC = 3;
  localparam int SMD_C_ADS = 2;
  localparam int SMD_C_DIR1 = 1;
  localparam int SMD_C_DIR0 = 0;

  // Counter and phase constants
  localparam logic [7:0] SMD_CNT_MAX = 8'hff;
  localparam logic [7:0] SMD_CNT_START = 8'h00;
  localparam logic [7:0] SMD_CNT_LOW1 = 8'h01;
  localparam logic [7:0] SMD_PHASE_STEP = 8'h40;
  localparam logic [7:0] SMD_RST_BYTE = 8'h00;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smd_bus_t;

  // One channel's four driver pins
  typedef struct packed {
    logic sin_p;
    logic sin_m;
    logic cos_p;
    logic cos_m;
  } smd_drv_t;

  // Whole block state
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dcs;
    logic [6:0] prs;
    logic [6:0] zprs;
    logic ext_s1;
    logic ext_s2;
    logic ext_d;
    logic [7:0] cnt;
    logic dither;
    logic [3:0][7:0] sin_mst;
    logic [3:0][7:0] cos_mst;
    logic [3:0][7:0] sin_slv;
    logic [3:0][7:0] cos_slv;
    logic [3:0][7:0] ctl;
    logic [3:0] zs1;
    logic [3:0] zs2;
    logic [3:0][2:0] zhist;
    logic [3:0] win;
    smd_drv_t [3:0] drv;
    logic [7:0] rdata;
  } smd_state_t;

  localparam smd_state_t SMD_STATE_RST = '0;

endpackage

//--- hdl/smd_driver.sv
// Four-channel stepper/meter PWM driver with zero-point detection
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module smd_driver (
  // Clock and reset
  input logic mclk,
  input logic reset,
  // Register port
  input smd_pkg::smd_bus_t bus,
  output logic [7:0] rdata,
  // Pins
  input logic ext_count_in,
  input logic [3:0] zero_cmp_in,
  output smd_pkg::smd_drv_t [3:0] drive,
  output logic [3:0] sense_mode
);
  import smd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State and helpers

  smd_state_t st;
  smd_state_t next_st;
  logic tick;
  logic ztick;
  logic ovf;
  logic ext_edge;
  smd_drv_t [3:0] route;

  // Power-of-two divider strobe from a free-running count
  function automatic logic due(input logic [6:0] c, input logic [2:0] n);
    logic [6:0] m;
    m = 7'((8'h01 << n) - 8'h01);
    due = ((c & m) == m);
  endfunction

  // External timer edge, read only after both sync flops
  assign ext_edge = st.ext_s2 & ~st.ext_d;

  // Count clock: divided prescaler or external edge
  assign tick = st.mode[SMD_M_SRC] ? ext_edge :
    due(st.prs, st.mode[2:0]);

  // Last count of the period
  assign ovf = st.mode[SMD_M_EN] & st.mode[SMD_M_RUN] & tick &
    (st.cnt == SMD_CNT_MAX);

  // Detector sampling strobe
  assign ztick = due(st.zprs, st.dcs[2:0]);

  ////////////////////////////////////////////////////////////////////////
  // Per-channel compare and pin routing

  for (genvar k = 0; k < 4; k++) begin : g_ch
    logic [7:0] ph;
    logic [8:0] sref;
    logic [8:0] cref;
    logic s_lvl;
    logic c_lvl;
    logic [7:0] c;
    assign c = st.ctl[k];
    // Staggered counter per channel so period starts never line up
    assign ph = st.cnt + SMD_PHASE_STEP * 8'(k);
    // Alternate periods add one count when dithering is on
    assign sref = {1'b0, st.sin_slv[k]} +
      {8'h00, c[SMD_C_ADS] & st.dither};
    assign cref = {1'b0, st.cos_slv[k]} +
      {8'h00, c[SMD_C_ADC] & st.dither};
    // High from period start until the match
    assign s_lvl = {1'b0, ph} < sref;
    assign c_lvl = {1'b0, ph} < cref;
    // Quadrant or all-pin routing
    always_comb begin
      route[k] = '0;
      if (c[SMD_C_AOUT]) begin
        route[k].sin_p = s_lvl;
        route[k].sin_m = s_lvl;
        route[k].cos_p = c_lvl;
        route[k].cos_m = c_lvl;
      end else begin
        route[k].sin_p = s_lvl & ~c[SMD_C_DIR1];
        route[k].sin_m = s_lvl & c[SMD_C_DIR1];
        route[k].cos_p = c_lvl & ~(c[SMD_C_DIR1] ^ c[SMD_C_DIR0]);
        route[k].cos_m = c_lvl & (c[SMD_C_DIR1] ^ c[SMD_C_DIR0]);
      end
      // Pin four becomes the sense input in the detect window
      if (c[SMD_C_WIN]) begin
        route[k].cos_m = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    // Free-running dividers
    next_st.prs = st.prs + 7'h01;
    next_st.zprs = st.zprs + 7'h01;
    // Synchronisers
    next_st.ext_s1 = ext_count_in;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_d = st.ext_s2;
    next_st.zs1 = zero_cmp_in;
    next_st.zs2 = st.zs1;
    // Shared counter
    if (!st.mode[SMD_M_EN]) begin
      next_st.cnt = SMD_CNT_START;
      next_st.dither = 1'b0;
    end else if (st.mode[SMD_M_RUN] && tick) begin
      if (ovf) begin
        // Wrap to range start
        next_st.cnt = st.mode[SMD_M_FULL] ? SMD_CNT_START :
          SMD_CNT_LOW1;
        next_st.dither = ~st.dither;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
    // Master-to-slave copy at period end, then transfer flag drops
    for (int k = 0; k < 4; k++) begin
      if (ovf && st.ctl[k][SMD_C_TEN]) begin
        next_st.sin_slv[k] = st.sin_mst[k];
        next_st.cos_slv[k] = st.cos_mst[k];
        next_st.ctl[k][SMD_C_TEN] = 1'b0;
      end
    end
    // Noise filter: three equal samples update the flag
    next_st.win = '0;
    for (int k = 0; k < 4; k++) begin
      next_st.win[k] = st.ctl[k][SMD_C_WIN];
      if (ztick) begin
        next_st.zhist[k] = {st.zhist[k][1:0], st.zs2[k]};
      end
      if (st.ctl[k][SMD_C_WIN] &&
          (&st.zhist[k] || ~|st.zhist[k])) begin
        next_st.ctl[k][SMD_C_ZPD] = st.zhist[k][0];
      end
    end
    // Writes come last so a set of the transfer flag beats the clear
    if (bus.wr) begin
      if (bus.addr == SMD_MODE_ADDR) begin
        next_st.mode = bus.wdata & SMD_MODE_WMASK;
      end
      if (bus.addr == SMD_DCS_ADDR) begin
        next_st.dcs = bus.wdata;
      end
      for (int k = 0; k < 4; k++) begin
        if (bus.addr == SMD_SIN_ADDR[k]) begin
          next_st.sin_mst[k] = bus.wdata;
        end
        if (bus.addr == SMD_COS_ADDR[k]) begin
          next_st.cos_mst[k] = bus.wdata;
        end
        if (bus.addr == SMD_CTL_ADDR[k]) begin
          // Detect flag is hardware-owned; writes to it are dropped
          next_st.ctl[k] = {bus.wdata[7:6], st.ctl[k][SMD_C_ZPD],
            bus.wdata[4:0]};
        end
      end
    end
    // Read data stands only in the cycle after the strobe
    next_st.rdata = SMD_RST_BYTE;
    if (bus.rd) begin
      if (bus.addr == SMD_MODE_ADDR) begin
        next_st.rdata = st.mode;
      end
      if (bus.addr == SMD_DCS_ADDR) begin
        next_st.rdata = st.dcs;
      end
      for (int k = 0; k < 4; k++) begin
        if (bus.addr == SMD_SIN_ADDR[k]) begin
          next_st.rdata = st.sin_mst[k];
        end
        if (bus.addr == SMD_COS_ADDR[k]) begin
          next_st.rdata = st.cos_mst[k];
        end
        if (bus.addr == SMD_CTL_ADDR[k]) begin
          next_st.rdata = st.ctl[k];
        end
      end
    end
    // Pins low whenever the unit is off
    next_st.drv = st.mode[SMD_M_EN] ? route : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= SMD_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign drive = st.drv;
  assign rdata = st.rdata;
  assign sense_mode = st.win;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_off_low;
    !st.mode[SMD_M_EN] |=> (drive == '0);
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("driver pins not low while unit disabled");

  property p_bit6_zero;
    bus.wr && bus.addr == SMD_MODE_ADDR |=> !st.mode[6];
  endproperty
  a_bit6_zero: assert property (p_bit6_zero)
    else $error("mode bit 6 took a written one");

  property p_stop_hold;
    st.mode[SMD_M_EN] && !st.mode[SMD_M_RUN] |=> $stable(st.cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved while stopped");

  property p_wrap;
    ovf |=> st.cnt == ($past(st.mode[SMD_M_FULL]) ? 8'h00 : 8'h01);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter wrapped to wrong start");

  property p_ten_clear;
    ovf && st.ctl[0][SMD_C_TEN] && !bus.wr |=> !st.ctl[0][SMD_C_TEN];
  endproperty
  a_ten_clear: assert property (p_ten_clear)
    else $error("transfer flag not cleared at period end");

  property p_copy;
    ovf && st.ctl[1][SMD_C_TEN] |=>
      st.sin_slv[1] == $past(st.sin_mst[1]) &&
      st.cos_slv[1] == $past(st.cos_mst[1]);
  endproperty
  a_copy: assert property (p_copy)
    else $error("slave compare not loaded from master");

  property p_read_mode;
    bus.rd && bus.addr == SMD_MODE_ADDR |=> rdata == $past(st.mode);
  endproperty
  a_read_mode: assert property (p_read_mode)
    else $error("mode read returned wrong value");

  property p_div1;
    !st.mode[SMD_M_SRC] && st.mode[2:0] == 3'h0 |-> tick;
  endproperty
  a_div1: assert property (p_div1)
    else $error("undivided count clock missed a cycle");

  property p_zpd_hold;
    !st.ctl[2][SMD_C_WIN] |=> $stable(st.ctl[2][SMD_C_ZPD]);
  endproperty
  a_zpd_hold: assert property (p_zpd_hold)
    else $error("detect flag changed outside window");

  property p_count_step;
    st.mode[SMD_M_EN] && st.mode[SMD_M_RUN] && tick && !ovf |=>
      st.cnt == $past(st.cnt) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");

endmodule

//--- dv/smd_coil_model.sv
// Model of the coils, back-EMF comparator and external count timer
`timescale 1ns/100ps
module smd_coil_model (
  // Clock
  input wire logic mclk,
  // Scenario controls
  input wire logic [3:0] bemf,
  input wire logic ext_on,
  // Driver side
  input wire smd_pkg::smd_drv_t [3:0] drive,
  input wire logic [3:0] sense_mode,
  // Levels sensed back
  output logic [3:0] zero_cmp,
  output logic ext_clk
);
  import smd_pkg::*;
  logic [1:0] div;
  initial begin
    ext_clk = 1'b0;
    div = 2'h0;
  end
  // Back-EMF seen only while pin four is released; else pin echoes drive
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      zero_cmp[k] = sense_mode[k] ? bemf[k] : drive[k].cos_m;
    end
  end
  // Timer output: one rising edge every eight mclk, still when off
  always @(posedge mclk) begin
    if (ext_on) begin
      div <= div + 2'h1;
      if (div == 2'h3) ext_clk <= ~ext_clk;
    end
  end
endmodule

//--- dv/smd_driver_tb.sv
// Self-checking bench for the stepper PWM driver
`timescale 1ns/100ps
module smd_driver_tb;
  import smd_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  smd_bus_t bus = '0;
  logic [7:0] rdata;
  logic ext_count_in;
  logic ext_on = 1'b0;
  logic [3:0] zero_cmp_in;
  logic [3:0] bemf = 4'h0;
  logic [3:0] sense_mode;
  smd_drv_t [3:0] drive;
  int n_errors = 0;
  int total_checks = 0;
  int c[4];
  int both;
  logic [7:0] v;

  smd_driver uut (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
    .ext_count_in(ext_count_in), .zero_cmp_in(zero_cmp_in),
    .drive(drive), .sense_mode(sense_mode));
  smd_coil_model coils (.mclk(mclk), .bemf(bemf), .ext_on(ext_on),
    .drive(drive), .sense_mode(sense_mode), .zero_cmp(zero_cmp_in),
    .ext_clk(ext_count_in));

  // Clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Gap cycle after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 v = rdata;
    @(posedge mclk);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // High time of one channel's pins over a window, sampled mid-cycle
  task automatic meas(input int ch, input int n);
    c = '{default: 0};
    both = 0;
    repeat (n) begin
      @(negedge mclk);
      c[0] += drive[ch].sin_p;
      c[1] += drive[ch].sin_m;
      c[2] += drive[ch].cos_p;
      c[3] += drive[ch].cos_m;
      both += drive[0].sin_p & drive[1].sin_p;
    end
    @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(SMD_MODE_ADDR);
    chk(v, 8'h00);
    wr(SMD_MODE_ADDR, 8'hff);
    rd(SMD_MODE_ADDR);
    chk(v, 8'hbf);
    rd(16'hf9e0);
    chk(v, 8'h00);
    wr(SMD_MODE_ADDR, 8'h00);
  endtask
  // Slaves load on overflow only; master rewrite waits for transfer
  task automatic t_pwm;
    wr(SMD_SIN_ADDR[0], 8'h10);
    wr(SMD_SIN_ADDR[1], 8'h10);
    wr(SMD_CTL_ADDR[0], 8'h90);
    wr(SMD_CTL_ADDR[1], 8'h90);
    wr(SMD_MODE_ADDR, 8'hb0);
    tk(300);
    rd(SMD_CTL_ADDR[0]);
    chk(v, 8'h80);
    wr(SMD_SIN_ADDR[0], 8'h20);
    meas(0, 256);
    chk(16'(c[0]), 16'h10);
    chk(16'(c[1]), 16'h10);
    chk(16'(both), 16'h0);
    meas(1, 256);
    chk(16'(c[0]), 16'h10);
    rd(SMD_SIN_ADDR[0]);
    chk(v, 8'h20);
  endtask
  // Both sides dithered; cosine slave is zero so it shows one count in two
  task automatic t_dither;
    wr(SMD_CTL_ADDR[0], 8'h8c);
    meas(0, 512);
    chk(16'(c[0]), 16'h21);
    chk(16'(c[2]), 16'h1);
    wr(SMD_CTL_ADDR[0], 8'h80);
  endtask
  task automatic t_route;
    wr(SMD_COS_ADDR[0], 8'h30);
    wr(SMD_CTL_ADDR[0], 8'h10);
    tk(300);
    for (int d = 0; d < 4; d++) begin
      wr(SMD_CTL_ADDR[0], 8'(d));
      meas(0, 256);
      chk(16'(c[0]), (d < 2) ? 16'h20 : 16'h0);
      chk(16'(c[1]), (d < 2) ? 16'h0 : 16'h20);
      chk(16'(c[2]), (d == 0 || d == 3) ? 16'h30 : 16'h0);
      chk(16'(c[3]), (d == 1 || d == 2) ? 16'h30 : 16'h0);
    end
    wr(SMD_CTL_ADDR[0], 8'h80);
  endtask
  task automatic t_clock;
    for (int d = 1; d < 8; d += 6) begin
      wr(SMD_MODE_ADDR, 8'hb0 | 8'(d));
      tk(20);
      meas(0, 256 << d);
      chk(16'(c[0]), 16'h20 << d);
    end
    wr(SMD_MODE_ADDR, 8'h90);
    tk(300);
    meas(0, 255);
    chk(16'(c[0]), 16'h1f);
    wr(SMD_MODE_ADDR, 8'ha0);
    tk(4);
    meas(0, 300);
    chk(16'(c[0] == 0 || c[0] == 300), 16'h1);
    ext_on <= 1'b1;
    wr(SMD_MODE_ADDR, 8'hb8);
    tk(40);
    meas(0, 2048);
    chk(16'(c[0]), 16'h100);
    ext_on <= 1'b0;
  endtask
  // Flag needs three equal samples; short glitch must not reach it
  task automatic t_zpd;
    wr(SMD_MODE_ADDR, 8'hb0);
    wr(SMD_DCS_ADDR, 8'h00);
    wr(SMD_CTL_ADDR[0], 8'hc0);
    // Sense flag lands on the edge the write task returns on; let it settle
    tk(1);
    chk(16'(sense_mode), 16'h1);
    bemf <= 4'h1;
    tk(1);
    bemf <= 4'h0;
    tk(20);
    rd(SMD_CTL_ADDR[0]);
    chk(v, 8'hc0);
    bemf <= 4'h1;
    tk(20);
    rd(SMD_CTL_ADDR[0]);
    chk(v, 8'he0);
    chk(16'(drive[0].cos_m), 16'h0);
    wr(SMD_DCS_ADDR, 8'h03);
    bemf <= 4'h0;
    tk(12);
    rd(SMD_CTL_ADDR[0]);
    chk(v, 8'he0);
    tk(40);
    rd(SMD_CTL_ADDR[0]);
    chk(v, 8'hc0);
  endtask
  task automatic t_off;
    wr(SMD_MODE_ADDR, 8'h30);
    tk(3);
    meas(0, 256);
    chk(16'(c[0] + c[1] + c[2] + c[3]), 16'h0);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Watchdog against a hung run
  initial begin
    #800000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    tk(2);
    chk(16'(drive), 16'h0);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_pwm();
    t_dither();
    t_route();
    t_clock();
    t_zpd();
    t_off();
    end_sim();
  end
endmodule
